// ### hw/oam_pkg.sv
// oam_pkg: constants, field layouts and carriers for the partner-side oam framer
// assumes one 125 MHz clock domain and a bit-serial fiber-side oam stream
package oam_pkg;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int          FRAME_BITS   = 96;
	localparam int          FRAME_BYTES  = 12;
	localparam int          PRE_BITS     = 8;
	localparam int          BODY_BITS    = 80;
	localparam int          FCS_BITS     = 8;
	localparam logic [7:0]  PREAMBLE     = 8'hAA;
	localparam logic [7:0]  FCS_POLY     = 8'h07;
	localparam logic [7:0]  FCS_INIT     = 8'h00;
	localparam logic [3:0]  VERSION      = 4'h0;
	localparam logic        DIR_UP       = 1'b0;
	localparam logic        DIR_DOWN     = 1'b1;
	localparam logic [1:0]  TYPE_REQ     = 2'b10;
	localparam logic [1:0]  TYPE_RSP     = 2'b11;
	localparam logic [1:0]  TYPE_IND     = 2'b01;
	localparam logic [7:0]  CMD_LOOP_GO  = 8'h80;
	localparam logic [7:0]  CMD_LOOP_END = 8'h00;
	localparam logic [7:0]  CMD_NOTIFY   = 8'h40;
	localparam int          FAULT_ONES   = 84;

	// status bit positions, index n is Sn
	localparam int S_PWR   = 0;
	localparam int S_OPT   = 1;
	localparam int S_LINK  = 2;
	localparam int S_FAULT = 3;
	localparam int S_WAY   = 4;
	localparam int S_LOOP  = 5;
	localparam int S_TERM  = 6;
	localparam int S_SPD1  = 7;
	localparam int S_SPD   = 8;
	localparam int S_DPX   = 9;
	localparam int S_ANEG  = 10;
	localparam int S_MULTI = 11;

	// ------------------------------------------------------------
	// register map (apb byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_LSTAT  = 8'h08;
	localparam logic [7:0] REG_LVEND  = 8'h0C;
	localparam logic [7:0] REG_LMODEL = 8'h10;
	localparam logic [7:0] REG_PSTAT  = 8'h14;
	localparam logic [7:0] REG_PVEND  = 8'h18;
	localparam logic [7:0] REG_PMODEL = 8'h1C;
	localparam logic [7:0] REG_COUNT  = 8'h20;
	localparam logic [7:0] REG_FLAGS  = 8'h24;

	localparam int CTRL_ROLE  = 0;
	localparam int CTRL_P3    = 1;
	localparam int CTRL_SEND  = 2;
	localparam int CTRL_FAULT = 3;
	localparam int CTRL_AUTO  = 4;
	localparam int FLG_BUSY   = 0;
	localparam int FLG_RXNEW  = 1;
	localparam int FLG_FCSERR = 2;
	localparam int FLG_LOOP   = 3;

	localparam logic [4:0]  CTRL_RST  = 5'h10;
	localparam logic [15:0] LSTAT_RST = 16'h0000;
	localparam logic [23:0] LVEND_RST = 24'h000000;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        dir;
		logic [1:0]  ftype;
		logic [7:0]  cmd;
		logic [15:0] stat;
		logic [23:0] vend;
		logic [23:0] model;
	} oam_fields_s;

	typedef struct packed {
		logic en;
		logic data;
	} oam_bit_s;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_FRAME = 2'b01,
		TX_FAULT = 2'b10
	} tx_state_e;

	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_BODY = 2'b01,
		RX_FCS  = 2'b10
	} rx_state_e;

endpackage

// ### hw/fcs_step.sv
// fcs_step: one serial step of the frame check sequence shift register
// assumes the caller registers the result; purely combinational
`timescale 1ns/10ps
module fcs_step #(
	parameter logic [7:0] POLY = 8'h07
) (
	// ------------------------------------------------------------
	// running value and next bit
	// ------------------------------------------------------------
	input  wire logic [7:0] crc,
	input  wire logic       din,
	// ------------------------------------------------------------
	// updated value
	// ------------------------------------------------------------
	output logic      [7:0] crc_out
);
	logic fb;

	always_comb begin
		fb      = crc[7] ^ din;
		crc_out = {crc[6:0], 1'b0} ^ (fb ? POLY : 8'h00);
	end
endmodule

// ### hw/oam_partner.sv
// oam_partner: partner-side oam framer with apb control, facing the converter fiber port
// assumes a bit-serial link with one bit per enabled clock, straps driven to the converter
`timescale 1ns/10ps
// How it works
// - frames are exactly 96 bits
// - preamble 10101010 marks frame start
// - C1 zero upstream, one downstream
// - type 10 request, 11 response, 01 indication
// - command byte selects loop start, stop, notify
// - S0 to S3 report local faults
// - S4 says how faults are conveyed
// - S5 set while in loop mode
// - S11 flags several copper partners
// - S12 to S15 sent as zero
// - vendor and model fields identify partner
// - trailing check byte verified before accept
module oam_partner
	import oam_pkg::*;
#(
	parameter logic [7:0] POLY = oam_pkg::FCS_POLY
) (
	// ------------------------------------------------------------
	// clock and reset
	// ------------------------------------------------------------
	input  wire logic             clk,
	input  wire logic             nrst,
	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// ------------------------------------------------------------
	// fiber-side oam bit stream
	// ------------------------------------------------------------
	output oam_pkg::oam_bit_s     link_tx,
	input  oam_pkg::oam_bit_s     link_rx,
	// ------------------------------------------------------------
	// converter straps and loop state
	// ------------------------------------------------------------
	output logic                  converter_port3_select,
	output logic                  converter_role_select,
	output logic                  loop_mode
);
	// ------------------------------------------------------------
	// register group
	// ------------------------------------------------------------
	logic [4:0]  ctrl, next_ctrl;
	logic [9:0]  cmd, next_cmd;
	logic [15:0] lstat, next_lstat;
	logic [23:0] lvend, next_lvend, lmodel, next_lmodel;
	oam_fields_s part, next_part;
	logic [15:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
	logic        rx_new, next_rx_new, fcs_err, next_fcs_err;
	logic        loop, next_loop;
	logic [15:0] prev_stat, next_prev_stat;
	logic [15:0] eff_stat;
	logic        wr, sw_send, notify;
	// rx to tx events
	logic        rx_ok, rx_bad;
	oam_fields_s rx_f;
	logic        tx_done, busy;
	logic [31:0] next_prdata;

	logic term;
	assign term = ctrl[CTRL_ROLE];
	assign wr   = psel & penable & pwrite;

	// outgoing status with the role-forced bits applied
	always_comb begin
		eff_stat         = lstat;
		eff_stat[S_LOOP] = loop;
		eff_stat[S_TERM] = term;
		eff_stat[S_SPD1] = 1'b0;
		if (!term || lstat[S_LINK]) begin
			eff_stat[S_SPD] = 1'b0;
			eff_stat[S_DPX] = 1'b0;
		end
		if (!term)
			eff_stat[S_ANEG] = 1'b0;
		eff_stat[15:12] = 4'h0;
	end

	always_comb begin
		next_ctrl      = ctrl;
		next_cmd       = cmd;
		next_lstat     = lstat;
		next_lvend     = lvend;
		next_lmodel    = lmodel;
		next_part      = part;
		next_tx_cnt    = tx_cnt;
		next_rx_cnt    = rx_cnt;
		next_rx_new    = rx_new;
		next_fcs_err   = fcs_err;
		next_loop      = loop;
		next_prev_stat = eff_stat;
		sw_send        = 1'b0;
		if (wr) begin
			case (paddr)
				REG_CTRL: begin
					next_ctrl = pwdata[4:0] & ~(5'h01 << CTRL_SEND);
					sw_send   = pwdata[CTRL_SEND];
				end
				REG_CMD:    next_cmd    = pwdata[9:0];
				REG_LSTAT:  next_lstat  = pwdata[15:0];
				REG_LVEND:  next_lvend  = pwdata[23:0];
				REG_LMODEL: next_lmodel = pwdata[23:0];
				REG_FLAGS: begin
					next_rx_new  = rx_new & ~pwdata[FLG_RXNEW];
					next_fcs_err = fcs_err & ~pwdata[FLG_FCSERR];
				end
				default: ;
			endcase
		end
		// hardware sets win over software clears
		if (rx_ok) begin
			next_part   = rx_f;
			next_rx_cnt = rx_cnt + 16'h0001;
			next_rx_new = 1'b1;
			// only a center request can move the terminal loop state
			if (term && rx_f.ftype == TYPE_REQ) begin
				if (rx_f.cmd == CMD_LOOP_GO)
					next_loop = 1'b1;
				else if (rx_f.cmd == CMD_LOOP_END)
					next_loop = 1'b0;
			end
		end
		if (rx_bad)
			next_fcs_err = 1'b1;
		// a role change to center drops the loop in the same edge
		if (!next_ctrl[CTRL_ROLE])
			next_loop = 1'b0;
		if (tx_done)
			next_tx_cnt = tx_cnt + 16'h0001;
	end

	assign notify = ctrl[CTRL_AUTO] && (eff_stat != prev_stat);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl      <= CTRL_RST;
			cmd       <= {TYPE_REQ, CMD_NOTIFY};
			lstat     <= LSTAT_RST;
			lvend     <= LVEND_RST;
			lmodel    <= LVEND_RST;
			part      <= '0;
			tx_cnt    <= 16'h0000;
			rx_cnt    <= 16'h0000;
			rx_new    <= 1'b0;
			fcs_err   <= 1'b0;
			loop      <= 1'b0;
			prev_stat <= LSTAT_RST;
			prdata    <= 32'h00000000;
		end else begin
			ctrl      <= next_ctrl;
			cmd       <= next_cmd;
			lstat     <= next_lstat;
			lvend     <= next_lvend;
			lmodel    <= next_lmodel;
			part      <= next_part;
			tx_cnt    <= next_tx_cnt;
			rx_cnt    <= next_rx_cnt;
			rx_new    <= next_rx_new;
			fcs_err   <= next_fcs_err;
			loop      <= next_loop;
			prev_stat <= next_prev_stat;
			prdata    <= next_prdata;
		end
	end

	// role and port three straps for the converter
	assign converter_role_select  = ctrl[CTRL_ROLE];
	assign converter_port3_select = ctrl[CTRL_P3] | ~ctrl[CTRL_ROLE];
	assign loop_mode              = loop;

	// ------------------------------------------------------------
	// apb read side
	// ------------------------------------------------------------
	// read data is registered in the setup cycle and stands through the access phase
	assign pready = 1'b1;
	always_comb begin
		next_prdata = 32'h00000000;
		pslverr     = 1'b0;
		case (paddr)
			REG_CTRL:   next_prdata = {27'h0, ctrl};
			REG_CMD:    next_prdata = {22'h0, cmd};
			REG_LSTAT:  next_prdata = {16'h0, eff_stat};
			REG_LVEND:  next_prdata = {8'h0, lvend};
			REG_LMODEL: next_prdata = {8'h0, lmodel};
			REG_PSTAT:  next_prdata = {5'h0, part.dir, part.ftype, part.cmd, part.stat};
			REG_PVEND:  next_prdata = {8'h0, part.vend};
			REG_PMODEL: next_prdata = {8'h0, part.model};
			REG_COUNT:  next_prdata = {rx_cnt, tx_cnt};
			REG_FLAGS:  next_prdata = {28'h0, loop, fcs_err, rx_new, busy};
			default:    pslverr = psel & penable;
		endcase
	end

	// ------------------------------------------------------------
	// transmit group
	// ------------------------------------------------------------
	tx_state_e   tx_st, next_tx_st;
	logic [87:0] tx_sh, next_tx_sh;
	logic [6:0]  tx_pos, next_tx_pos;
	logic [7:0]  tx_crc, next_tx_crc, tx_crc_step;
	logic        pend_rsp, next_pend_rsp, pend_sw, next_pend_sw;
	logic        pend_ntf, next_pend_ntf;
	logic [7:0]  rsp_cmd, next_rsp_cmd;
	logic [6:0]  flt_cnt, next_flt_cnt;
	oam_bit_s    next_link_tx;
	logic        tx_dir;
	logic [1:0]  tx_type;
	logic [7:0]  tx_cmd;
	logic [15:0] eff_stat_rev;

	fcs_step #(.POLY(POLY)) u_tx_fcs (
		.crc     (tx_crc),
		.din     (tx_sh[87]),
		.crc_out (tx_crc_step)
	);

	assign tx_dir = term ? DIR_UP : DIR_DOWN;
	assign eff_stat_rev = {<<{eff_stat}};
	assign busy   = (tx_st == TX_FRAME);

	always_comb begin
		next_tx_st    = tx_st;
		next_tx_sh    = tx_sh;
		next_tx_pos   = tx_pos;
		next_tx_crc   = tx_crc;
		next_pend_rsp = pend_rsp | (rx_ok && term && rx_f.ftype == TYPE_REQ);
		next_pend_sw  = pend_sw | (sw_send && !term);
		next_pend_ntf = pend_ntf | notify;
		next_rsp_cmd  = (rx_ok && term) ? rx_f.cmd : rsp_cmd;
		next_flt_cnt  = flt_cnt;
		next_link_tx  = '{en: 1'b0, data: 1'b0};
		tx_done       = 1'b0;
		// answers first, then software requests, then notifications
		tx_type = TYPE_IND;
		tx_cmd  = CMD_NOTIFY;
		if (pend_rsp) begin
			tx_type = TYPE_RSP;
			tx_cmd  = rsp_cmd;
		end else if (pend_sw) begin
			tx_type = cmd[9:8];
			tx_cmd  = cmd[7:0];
		end
		case (tx_st)
			TX_IDLE, TX_FAULT: begin
				if (pend_rsp || pend_sw || pend_ntf) begin
					// the frame leaves msb first: preamble, C0 .. C15, S0 .. S15, M0 .. M47
					next_tx_sh = {PREAMBLE, 1'b0, tx_dir, tx_type, VERSION, tx_cmd,
						eff_stat_rev, lvend, lmodel};
					next_tx_pos   = 7'd0;
					next_tx_crc   = FCS_INIT;
					next_tx_st    = TX_FRAME;
					next_pend_rsp = 1'b0;
					next_pend_sw  = pend_rsp ? next_pend_sw : 1'b0;
					next_pend_ntf = notify;
				end else if (ctrl[CTRL_FAULT]) begin
					next_tx_st   = TX_FAULT;
					next_link_tx = '{en: 1'b1, data: (flt_cnt != 7'(FAULT_ONES))};
					next_flt_cnt = (flt_cnt == 7'(FAULT_ONES)) ? 7'd0 : flt_cnt + 7'd1;
				end else begin
					next_tx_st   = TX_IDLE;
					next_flt_cnt = 7'd0;
					// terminal loop turns the received stream straight back
					if (loop)
						next_link_tx = link_rx;
				end
			end
			TX_FRAME: begin
				next_tx_pos = tx_pos + 7'd1;
				if (tx_pos < 7'(PRE_BITS + BODY_BITS)) begin
					next_link_tx = '{en: 1'b1, data: tx_sh[87]};
					next_tx_sh   = {tx_sh[86:0], 1'b0};
					if (tx_pos >= 7'(PRE_BITS))
						next_tx_crc = tx_crc_step;
				end else begin
					next_link_tx = '{en: 1'b1, data: tx_crc[7]};
					next_tx_crc  = {tx_crc[6:0], 1'b0};
				end
				if (tx_pos == 7'(FRAME_BITS - 1)) begin
					next_tx_st = TX_IDLE;
					tx_done    = 1'b1;
				end
			end
			default: next_tx_st = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_st    <= TX_IDLE;
			tx_sh    <= '0;
			tx_pos   <= 7'd0;
			tx_crc   <= FCS_INIT;
			pend_rsp <= 1'b0;
			pend_sw  <= 1'b0;
			pend_ntf <= 1'b0;
			rsp_cmd  <= CMD_NOTIFY;
			flt_cnt  <= 7'd0;
			link_tx  <= '{en: 1'b0, data: 1'b0};
		end else begin
			tx_st    <= next_tx_st;
			tx_sh    <= next_tx_sh;
			tx_pos   <= next_tx_pos;
			tx_crc   <= next_tx_crc;
			pend_rsp <= next_pend_rsp;
			pend_sw  <= next_pend_sw;
			pend_ntf <= next_pend_ntf;
			rsp_cmd  <= next_rsp_cmd;
			flt_cnt  <= next_flt_cnt;
			link_tx  <= next_link_tx;
		end
	end

	// ------------------------------------------------------------
	// receive group
	// ------------------------------------------------------------
	rx_state_e   rx_st, next_rx_st;
	logic [7:0]  rx_hist, next_rx_hist;
	logic [79:0] rx_sh, next_rx_sh;
	logic [6:0]  rx_pos, next_rx_pos;
	logic [7:0]  rx_crc, next_rx_crc, rx_crc_step;
	logic [7:0]  rx_fcs, next_rx_fcs;
	logic [15:0] rx_stat_raw, rx_stat_rev;

	fcs_step #(.POLY(POLY)) u_rx_fcs (
		.crc     (rx_crc),
		.din     (link_rx.data),
		.crc_out (rx_crc_step)
	);

	assign rx_stat_raw = rx_sh[63:48];
	assign rx_stat_rev = {<<{rx_stat_raw}};
	assign rx_f = '{dir: rx_sh[78], ftype: rx_sh[77:76], cmd: rx_sh[71:64],
		stat: rx_stat_rev, vend: rx_sh[47:24], model: rx_sh[23:0]};

	always_comb begin
		next_rx_st   = rx_st;
		next_rx_hist = rx_hist;
		next_rx_sh   = rx_sh;
		next_rx_pos  = rx_pos;
		next_rx_crc  = rx_crc;
		next_rx_fcs  = rx_fcs;
		rx_ok        = 1'b0;
		rx_bad       = 1'b0;
		if (link_rx.en) begin
			case (rx_st)
				RX_HUNT: begin
					next_rx_hist = {rx_hist[6:0], link_rx.data};
					if ({rx_hist[6:0], link_rx.data} == PREAMBLE) begin
						next_rx_st  = RX_BODY;
						next_rx_pos = 7'd0;
						next_rx_crc = FCS_INIT;
					end
				end
				RX_BODY: begin
					next_rx_sh  = {rx_sh[78:0], link_rx.data};
					next_rx_crc = rx_crc_step;
					next_rx_pos = rx_pos + 7'd1;
					if (rx_pos == 7'(BODY_BITS - 1)) begin
						next_rx_st  = RX_FCS;
						next_rx_pos = 7'd0;
					end
				end
				RX_FCS: begin
					next_rx_fcs = {rx_fcs[6:0], link_rx.data};
					next_rx_pos = rx_pos + 7'd1;
					if (rx_pos == 7'(FCS_BITS - 1)) begin
						next_rx_st   = RX_HUNT;
						next_rx_hist = 8'h00;
						// a frame from the same role as ours is not from the partner
						if ({rx_fcs[6:0], link_rx.data} == rx_crc
							&& rx_sh[75:72] == VERSION && rx_sh[79] == 1'b0
							&& rx_sh[78] != tx_dir && rx_sh[77:76] != 2'b00)
							rx_ok = 1'b1;
						else
							rx_bad = 1'b1;
					end
				end
				default: next_rx_st = RX_HUNT;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_st   <= RX_HUNT;
			rx_hist <= 8'h00;
			rx_sh   <= '0;
			rx_pos  <= 7'd0;
			rx_crc  <= FCS_INIT;
			rx_fcs  <= 8'h00;
		end else begin
			rx_st   <= next_rx_st;
			rx_hist <= next_rx_hist;
			rx_sh   <= next_rx_sh;
			rx_pos  <= next_rx_pos;
			rx_crc  <= next_rx_crc;
			rx_fcs  <= next_rx_fcs;
		end
	end
endmodule

// ### sim/oam_partner_props.sv
// oam_partner_props: port-level checks for oam_partner
// assumes one clk domain; bound onto every oam_partner instance
`timescale 1ns/10ps
module oam_partner_props
	import oam_pkg::*;
(
	// clock, reset, apb
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// link and straps
	input wire oam_pkg::oam_bit_s link_tx,
	input wire oam_pkg::oam_bit_s link_rx,
	input wire logic              converter_port3_select,
	input wire logic              converter_role_select,
	input wire logic              loop_mode
);
	logic       fault_en, next_fault_en, clean, next_clean, wr_ctrl;
	logic [1:0] strap, next_strap;
	logic [6:0] run, next_run, ones, next_ones;
	// ----------------
	// helper state
	// ----------------
	always_comb begin
		wr_ctrl = psel && penable && pwrite && (paddr == REG_CTRL);
		next_fault_en = wr_ctrl ? pwdata[CTRL_FAULT] : fault_en;
		next_strap = wr_ctrl ? {pwdata[CTRL_ROLE], pwdata[CTRL_P3] | !pwdata[CTRL_ROLE]} : strap;
		next_run = !link_tx.en ? 7'h00 : run + {6'h00, run != 7'h7F};
		next_ones = (link_tx != 2'b11) ? 7'h00 : ones + {6'h00, ones != 7'h7F};
		// runs touched by loop echo or fault idle are not frames
		next_clean = !link_tx.en || (clean && !loop_mode && !fault_en);
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_en <= 1'b0;
			strap <= 2'b01;
			run <= 7'h00;
			ones <= 7'h00;
			clean <= 1'b1;
		end else begin
			fault_en <= next_fault_en;
			strap <= next_strap;
			run <= next_run;
			ones <= next_ones;
			clean <= next_clean;
		end
	end
	// ----------------
	// properties
	// ----------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence preamble_s;
		link_tx == 2'b11 ##1 link_tx == 2'b10 ##1 link_tx == 2'b11 ##1 link_tx == 2'b10
		##1 link_tx == 2'b11 ##1 link_tx == 2'b10 ##1 link_tx == 2'b11 ##1 link_tx == 2'b10;
	endsequence
	sequence send_s;
		wr_ctrl && pwdata[CTRL_SEND] && !pwdata[CTRL_ROLE] && !converter_role_select
		&& !fault_en && !link_tx.en;
	endsequence
	a_frame_preamble: assert property (
		$rose(link_tx.en) && !fault_en && !loop_mode && !$past(loop_mode) |-> preamble_s)
		else $error("frame does not open with the preamble");
	a_frame_length: assert property (
		!link_tx.en && $past(link_tx.en) && clean |-> run == 7'h60)
		else $error("frame length is not 96 bits");
	a_send_start: assert property (send_s |-> ##[1:4] link_tx.en)
		else $error("send request did not start a frame");
	a_fault_zero: assert property (
		fault_en && !loop_mode && ones == 7'h54 |-> link_tx == 2'b10)
		else $error("fault pattern lacks zero after 84 ones");
	a_strap_center: assert property (!converter_role_select |-> converter_port3_select)
		else $error("center role without port3 strap");
	a_strap_follow: assert property (
		wr_ctrl |=> ##1 {converter_role_select, converter_port3_select} == strap)
		else $error("straps do not follow control");
	a_loop_role: assert property (loop_mode |-> converter_role_select)
		else $error("loop mode outside terminal role");
	a_err_unmapped: assert property (
		psel && penable && paddr > REG_FLAGS |-> pslverr && (pwrite || prdata == 32'h00000000))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (
		psel && penable && paddr <= REG_FLAGS && paddr[1:0] == 2'h0 |-> pready && !pslverr)
		else $error("mapped access refused");
endmodule
bind oam_partner oam_partner_props u_oam_partner_props (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .link_tx(link_tx), .link_rx(link_rx),
	.converter_port3_select(converter_port3_select),
	.converter_role_select(converter_role_select), .loop_mode(loop_mode));

// ### sim/oam_device_model.sv
// oam_device_model: behavioural media converter on the fiber side
// assumes one bit per clock each way; the bench hands it whole frames
`timescale 1ns/10ps
module oam_device_model
	import oam_pkg::*;
(
	// clock, reset, bench control
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              send_go,
	input  wire logic [95:0]       send_frame,
	// fiber bit streams
	input  wire oam_pkg::oam_bit_s link_tx,
	output oam_pkg::oam_bit_s      link_rx,
	output logic      [95:0]       got_frame
);
	logic [95:0] shreg;
	logic [95:0] txreg;
	logic [6:0]  run;
	logic [6:0]  left;
	logic        idle_bit;
	// idle line flips each cycle so a stale bit never passes as data
	assign link_rx = {(left != 7'h00), (left != 7'h00) ? txreg[95] : idle_bit};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shreg <= '0;
			txreg <= '0;
			got_frame <= '0;
			run <= 7'h00;
			left <= 7'h00;
			idle_bit <= 1'b0;
		end else begin
			idle_bit <= !idle_bit;
			if (link_tx.en) begin
				shreg <= {shreg[94:0], link_tx.data};
				run <= (run == 7'h7F) ? run : run + 7'h01;
			end else begin
				// only a run of exactly one frame is taken
				if (run == 7'h60) begin
					got_frame <= shreg;
				end
				run <= 7'h00;
			end
			if (send_go) begin
				txreg <= send_frame;
				left <= 7'h60;
			end else if (left != 7'h00) begin
				txreg <= {txreg[94:0], 1'b0};
				left <= left - 7'h01;
			end
		end
	end
endmodule

// ### sim/oam_partner_tb.sv
// oam_partner_tb: self-checking bench for oam_partner
// assumes oam_device_model on the fiber side and the bound checker
`timescale 1ns/10ps
`define CHECK(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module oam_partner_tb;
	import oam_pkg::*;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wd;
		logic [31:0] exp;
		logic        err;
	} row_s;
	logic              clk, nrst, psel, penable, pwrite, pready, pslverr, er, role, p3, loop_mode;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [95:0]       send_frame, got_frame;
	logic              send_go;
	oam_pkg::oam_bit_s link_tx, link_rx;
	row_s              rows [7];
	logic [7:0]        cmds [3];
	int                failures, cmp_count, i, odd;
	oam_partner u_oam_partner (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_tx(link_tx), .link_rx(link_rx), .converter_port3_select(p3),
		.converter_role_select(role), .loop_mode(loop_mode));
	oam_device_model u_oam_device_model (.clk(clk), .nrst(nrst), .send_go(send_go),
		.send_frame(send_frame), .link_tx(link_tx), .link_rx(link_rx), .got_frame(got_frame));
	// ----------------
	// helpers
	// ----------------
	function automatic logic [95:0] frame_of(input logic dir, input logic [1:0] ty,
		input logic [7:0] cmd, input logic [15:0] st, input logic [23:0] ven);
		logic [15:0] sr;
		logic [79:0] body;
		logic [7:0]  fcs;
		for (int k = 0; k < 16; k++)
			sr[k] = st[15 - k];
		body = {1'b0, dir, ty, VERSION, cmd, sr, ven, ~ven};
		fcs = FCS_INIT;
		for (int k = 79; k >= 0; k--)
			fcs = {fcs[6:0], 1'b0} ^ ((fcs[7] ^ body[k]) ? FCS_POLY : 8'h00);
		return {PREAMBLE, body, fcs};
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic far_send(input logic [95:0] f);
		@(posedge clk);
		send_go <= 1'b1;
		send_frame <= f;
		@(posedge clk);
		send_go <= 1'b0;
	endtask
	task automatic expect_frame(input logic [95:0] exp);
		for (int k = 0; k < 400 && got_frame !== exp; k++)
			@(posedge clk);
		`CHECK(got_frame, exp)
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (10000) @(posedge clk);
		failures++;
		finish_test;
	end
	// ----------------
	// main sequence
	// ----------------
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, send_go, send_frame} = '0;
		failures = 0;
		cmp_count = 0;
		cmds = '{CMD_LOOP_GO, CMD_LOOP_END, CMD_NOTIFY};
		rows = '{'{REG_CTRL, 32'h00000000, 32'h00000000, 1'b0},
			'{REG_LSTAT, 32'h0000FFFF, 32'h0000081F, 1'b0},
			'{REG_LVEND, 32'hFF123456, 32'h00123456, 1'b0},
			'{REG_LMODEL, 32'h00EDCBA9, 32'h00EDCBA9, 1'b0},
			'{REG_CMD, 32'h00000280, 32'h00000280, 1'b0},
			'{REG_COUNT, 32'hFFFFFFFF, 32'h00000000, 1'b0},
			'{8'h30, 32'h00000001, 32'h00000000, 1'b1}};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0);
		`CHECK(rd, 32'h00000010)
		`CHECK({role, p3, loop_mode, link_tx.en}, 4'b0100)
		$display("test reset done");
		for (i = 0; i < 7; i++) begin
			apb(1'b1, rows[i].addr, rows[i].wd);
			apb(1'b0, rows[i].addr, 32'h0);
			`CHECK(rd, rows[i].exp)
			`CHECK(er, rows[i].err)
		end
		$display("test registers done");
		for (i = 0; i < 3; i++) begin
			apb(1'b1, REG_CMD, {22'h0, TYPE_REQ, cmds[i]});
			apb(1'b1, REG_CTRL, 32'h00000004);
			expect_frame(frame_of(DIR_DOWN, TYPE_REQ, cmds[i], 16'h081F, 24'h123456));
		end
		apb(1'b0, REG_COUNT, 32'h0);
		`CHECK(rd, 32'h00000003)
		$display("test center requests done");
		apb(1'b1, REG_CTRL, 32'h00000003);
		repeat (2) @(posedge clk);
		`CHECK({role, p3}, 2'b11)
		apb(1'b1, REG_CTRL, 32'h00000001);
		apb(1'b1, REG_LSTAT, 32'h00000B03);
		`CHECK({role, p3}, 2'b10)
		apb(1'b0, REG_LSTAT, 32'h0);
		`CHECK(rd, 32'h00000B43)
		far_send(frame_of(DIR_DOWN, TYPE_REQ, CMD_LOOP_GO, 16'h0000, 24'h0A0B0C));
		expect_frame(frame_of(DIR_UP, TYPE_RSP, CMD_LOOP_GO, 16'h0B63, 24'h123456));
		`CHECK(loop_mode, 1'b1)
		apb(1'b0, REG_PSTAT, 32'h0);
		`CHECK(rd, 32'h06800000)
		apb(1'b0, REG_PVEND, 32'h0);
		`CHECK(rd, 32'h000A0B0C)
		far_send(96'h00FF00FF00FF00FF00FF00FF);
		expect_frame(96'h00FF00FF00FF00FF00FF00FF);
		far_send(frame_of(DIR_DOWN, TYPE_REQ, CMD_LOOP_END, 16'h0000, 24'h0A0B0C));
		expect_frame(frame_of(DIR_UP, TYPE_RSP, CMD_LOOP_END, 16'h0B43, 24'h123456));
		`CHECK(loop_mode, 1'b0)
		$display("test terminal loop done");
		far_send(frame_of(DIR_DOWN, TYPE_REQ, CMD_NOTIFY, 16'h0000, 24'h0A0B0C) ^ 96'h1);
		rd = 32'h00000000;
		for (i = 0; i < 60 && rd[FLG_FCSERR] !== 1'b1; i++)
			apb(1'b0, REG_FLAGS, 32'h0);
		`CHECK(rd[FLG_FCSERR], 1'b1)
		`CHECK(rd[FLG_RXNEW], 1'b1)
		apb(1'b0, REG_PSTAT, 32'h0);
		`CHECK(rd, 32'h06000000)
		apb(1'b0, REG_COUNT, 32'h0);
		`CHECK(rd, 32'h00020005)
		apb(1'b1, REG_FLAGS, 32'h00000004);
		apb(1'b0, REG_FLAGS, 32'h0);
		`CHECK(rd[FLG_FCSERR], 1'b0)
		$display("test bad check done");
		apb(1'b1, REG_CTRL, 32'h00000011);
		apb(1'b1, REG_LSTAT, 32'h00000B02);
		expect_frame(frame_of(DIR_UP, TYPE_IND, CMD_NOTIFY, 16'h0B42, 24'h123456));
		$display("test auto notify done");
		apb(1'b1, REG_CTRL, 32'h00000009);
		repeat (FAULT_ONES) @(posedge clk);
		odd = 0;
		repeat (2 * (FAULT_ONES + 1)) begin
			@(posedge clk);
			if (link_tx !== 2'b11)
				odd++;
		end
		`CHECK(odd, 2)
		$display("test fault pattern done");
		finish_test;
	end
endmodule
